// [rtl/vref_pkg.sv]
// constants shared by the reference ladder control block
package vref_pkg;

	// ****************************************
	// clock and bus
	// ****************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned HZ_PER_MHZ = 1_000_000;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ****************************************
	// register map (index, byte address is four times it)
	// ****************************************
	localparam logic [7:0] CTRL_IDX = 8'h9F;
	localparam logic [7:0] STAT_IDX = 8'hA0;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

	// ****************************************
	// control register fields
	// ****************************************
	localparam int unsigned POWER_BIT = 7;
	localparam int unsigned PIN_BIT = 6;
	localparam int unsigned RANGE_BIT = 5;
	localparam int unsigned UNUSED_BIT = 4;
	localparam int unsigned TAP_LSB = 0;
	localparam int unsigned TAP_W = 4;
	localparam int unsigned TAPS = 16;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hEF;

	// ****************************************
	// status register fields
	// ****************************************
	localparam int unsigned STAT_SETTLE_BIT = 0;
	localparam int unsigned STAT_LIVE_BIT = 1;
	localparam int unsigned STAT_NUM_LSB = 8;
	localparam int unsigned STAT_DEN_LSB = 16;

	// ****************************************
	// ladder ratios, level = num / den of the supply
	// ****************************************
	localparam int unsigned RATIO_W = 6;
	localparam logic [RATIO_W-1:0] LOW_DEN = 6'h18;
	localparam logic [RATIO_W-1:0] HIGH_DEN = 6'h20;
	localparam logic [RATIO_W-1:0] HIGH_BASE = 6'h08;

endpackage

// [rtl/vref_ladder_if.sv]
// carrier between the register logic and the tap decoder
`timescale 1ns/100ps
interface vref_ladder_if;
	// next register contents, driven by the register logic
	logic power_d;
	logic low_range_d;
	logic [vref_pkg::TAP_W-1:0] tap_d;
	// decoded ladder state, driven by the decoder
	logic [vref_pkg::TAPS-1:0] low_onehot;
	logic [vref_pkg::TAPS-1:0] high_onehot;
	logic [vref_pkg::RATIO_W-1:0] ratio_num;
	logic [vref_pkg::RATIO_W-1:0] ratio_den;

	modport regs (output power_d, low_range_d, tap_d,
		input low_onehot, high_onehot, ratio_num, ratio_den);
	modport dec (input power_d, low_range_d, tap_d,
		output low_onehot, high_onehot, ratio_num, ratio_den);
endinterface

// [rtl/vref_apb_decode.sv]
// apb phase and address decode for the reference ladder registers
`timescale 1ns/100ps
module vref_apb_decode (
	// apb request
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [vref_pkg::ADDR_W-1:0] paddr_i,
	// decoded strobes
	output logic setup_o,
	output logic access_o,
	output logic hit_ctrl_o,
	output logic hit_stat_o,
	output logic unmapped_o,
	output logic wr_ctrl_o
);

	// phases: setup loads read data, access commits writes
	assign setup_o = psel_i & ~penable_i;
	assign access_o = psel_i & penable_i;

	// full address compare, misaligned addresses fall to unmapped
	assign hit_ctrl_o = (paddr_i == vref_pkg::CTRL_ADDR);
	assign hit_stat_o = (paddr_i == vref_pkg::STAT_ADDR);
	assign unmapped_o = ~hit_ctrl_o & ~hit_stat_o;
	assign wr_ctrl_o = access_o & pwrite_i & hit_ctrl_o;

endmodule

// [rtl/vref_tap_decoder.sv]
// tap select decoder for the two ladder ranges
`timescale 1ns/100ps
module vref_tap_decoder (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// ladder carrier
	vref_ladder_if.dec lad
);

	// one tap line out of sixteen
	function automatic logic [vref_pkg::TAPS-1:0] tap_line(
		input logic [vref_pkg::TAP_W-1:0] tap);
		tap_line = '0;
		tap_line[tap] = 1'b1;
	endfunction

	logic [vref_pkg::TAPS-1:0] low_d;
	logic [vref_pkg::TAPS-1:0] high_d;
	logic [vref_pkg::RATIO_W-1:0] num_d;
	logic [vref_pkg::RATIO_W-1:0] den_d;
	logic [vref_pkg::TAPS-1:0] low_q;
	logic [vref_pkg::TAPS-1:0] high_q;
	logic [vref_pkg::RATIO_W-1:0] num_q;
	logic [vref_pkg::RATIO_W-1:0] den_q;

	// tap lines are dropped while powered down so no segment conducts
	assign low_d = (lad.power_d & lad.low_range_d) ? tap_line(lad.tap_d) : '0;
	assign high_d = (lad.power_d & ~lad.low_range_d) ? tap_line(lad.tap_d) : '0;
	// low range n/24, high range quarter plus n/32
	assign num_d = lad.low_range_d ? {2'h0, lad.tap_d}
		: vref_pkg::HIGH_BASE + {2'h0, lad.tap_d};
	assign den_d = lad.low_range_d ? vref_pkg::LOW_DEN : vref_pkg::HIGH_DEN;

	// registered with the control register so both move on one edge
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_q <= '0;
			high_q <= '0;
			num_q <= vref_pkg::HIGH_BASE;
			den_q <= vref_pkg::HIGH_DEN;
		end else begin
			low_q <= low_d;
			high_q <= high_d;
			num_q <= num_d;
			den_q <= den_d;
		end
	end

	assign lad.low_onehot = low_q;
	assign lad.high_onehot = high_q;
	assign lad.ratio_num = num_q;
	assign lad.ratio_den = den_q;

endmodule

// [rtl/vref_ladder_control.sv]
// apb control register and ladder drive for the 16-tap voltage reference
`timescale 1ns/100ps
module vref_ladder_control #(
	parameter int unsigned SETTLE_NS = 10000
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [vref_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [vref_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [vref_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// ladder controls
	output logic ladder_power_on_o,
	output logic ladder_pin_connect_o,
	output logic ladder_low_range_o,
	output logic [vref_pkg::TAP_W-1:0] ladder_tap_select_o,
	output logic [vref_pkg::TAPS-1:0] ladder_low_taps_o,
	output logic [vref_pkg::TAPS-1:0] ladder_high_taps_o,
	output logic [vref_pkg::RATIO_W-1:0] ladder_ratio_num_o,
	output logic [vref_pkg::RATIO_W-1:0] ladder_ratio_den_o,
	output logic ladder_settling_o
);

	// ****************************************
	// timing
	// ****************************************

	// settling window, rounded up to whole cycles and never below one
	localparam int unsigned SETTLE_RAW =
		(SETTLE_NS * (vref_pkg::CLK_HZ / vref_pkg::HZ_PER_MHZ) + vref_pkg::NS_PER_US - 1)
		/ vref_pkg::NS_PER_US;
	localparam int unsigned SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
	localparam int unsigned SETTLE_CW = $clog2(SETTLE_CYC + 1);
	localparam logic [SETTLE_CW-1:0] SETTLE_LOAD = SETTLE_CW'(SETTLE_CYC);

	// ****************************************
	// bus decode
	// ****************************************

	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_stat;
	logic unmapped;
	logic wr_ctrl;

	vref_apb_decode u_decode (
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.setup_o(setup),
		.access_o(access),
		.hit_ctrl_o(hit_ctrl),
		.hit_stat_o(hit_stat),
		.unmapped_o(unmapped),
		.wr_ctrl_o(wr_ctrl)
	);

	// ****************************************
	// control register
	// ****************************************

	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic ctrl_wr;
	logic ctrl_change;

	// only the low byte lane carries the register, so its strobe gates it
	assign ctrl_wr = wr_ctrl & pready_o & pstrb_i[0];
	// bit 4 is masked off here so it can never be stored
	assign ctrl_d = ctrl_wr ? (pwdata_i[7:0] & vref_pkg::CTRL_WMASK) : ctrl_q;
	assign ctrl_change = ctrl_wr & (ctrl_d != ctrl_q);

	// the register itself
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_q <= vref_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// field outputs come straight from the register flops
	assign ladder_power_on_o = ctrl_q[vref_pkg::POWER_BIT];
	assign ladder_pin_connect_o = ctrl_q[vref_pkg::PIN_BIT];
	assign ladder_low_range_o = ctrl_q[vref_pkg::RANGE_BIT];
	assign ladder_tap_select_o = ctrl_q[vref_pkg::TAP_LSB +: vref_pkg::TAP_W];

	// ****************************************
	// tap decoder
	// ****************************************

	vref_ladder_if lad ();

	// decoder is fed the next value so its flops land on the same edge
	assign lad.power_d = ctrl_d[vref_pkg::POWER_BIT];
	assign lad.low_range_d = ctrl_d[vref_pkg::RANGE_BIT];
	assign lad.tap_d = ctrl_d[vref_pkg::TAP_LSB +: vref_pkg::TAP_W];

	vref_tap_decoder u_taps (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.lad(lad)
	);

	assign ladder_low_taps_o = lad.low_onehot;
	assign ladder_high_taps_o = lad.high_onehot;
	assign ladder_ratio_num_o = lad.ratio_num;
	assign ladder_ratio_den_o = lad.ratio_den;

	// ****************************************
	// settling tracker
	// ****************************************

	logic [SETTLE_CW-1:0] settle_q;
	logic [SETTLE_CW-1:0] settle_d;

	// any change of level restarts the window; the analog settling
	// itself is not observed, so this is only a conservative estimate
	assign settle_d = ctrl_change ? SETTLE_LOAD
		: (settle_q != '0) ? settle_q - SETTLE_CW'(1) : settle_q;

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			settle_q <= '0;
		end else begin
			settle_q <= settle_d;
		end
	end

	assign ladder_settling_o = (settle_q != '0);

	// ****************************************
	// read path and answer
	// ****************************************

	logic [vref_pkg::DATA_W-1:0] ctrl_rd;
	logic [vref_pkg::DATA_W-1:0] stat_rd;
	logic [vref_pkg::DATA_W-1:0] rdata_d;
	logic [vref_pkg::DATA_W-1:0] rdata_q;
	logic err_q;

	// upper bits and bit 4 read as zero
	assign ctrl_rd = {24'h000000, ctrl_q};
	always_comb begin
		stat_rd = '0;
		stat_rd[vref_pkg::STAT_SETTLE_BIT] = ladder_settling_o;
		stat_rd[vref_pkg::STAT_LIVE_BIT] = |(lad.low_onehot | lad.high_onehot);
		stat_rd[vref_pkg::STAT_NUM_LSB +: vref_pkg::RATIO_W] = lad.ratio_num;
		stat_rd[vref_pkg::STAT_DEN_LSB +: vref_pkg::RATIO_W] = lad.ratio_den;
	end
	assign rdata_d = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : '0;

	// read data is latched in the setup cycle, so the slave never waits;
	// the single master cannot change the register between the two phases
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_q <= '0;
			err_q <= 1'b0;
		end else if (setup) begin
			rdata_q <= rdata_d;
			err_q <= unmapped;
		end
	end

	assign prdata_o = rdata_q;
	assign pready_o = 1'b1;
	assign pslverr_o = err_q & access;

	// ****************************************
	// checks
	// ****************************************

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// helper: first cycle after reset release
	logic first_q;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	reset_clear_a: assert property (first_q |-> ctrl_q == 8'h00 && !ladder_power_on_o
		&& !ladder_pin_connect_o && !ladder_low_range_o && ladder_tap_select_o == 4'h0
		&& ladder_high_taps_o == 16'h0000 && ladder_ratio_den_o == 6'h20)
		else $error("control state not cleared after reset");

	power_follow_a: assert property (ctrl_wr |=> ladder_power_on_o == $past(pwdata_i[7])
		&& (ladder_power_on_o || (ladder_low_taps_o | ladder_high_taps_o) == 16'h0000))
		else $error("ladder power does not follow the written bit");

	pin_follow_a: assert property (ctrl_wr |=> ladder_pin_connect_o == $past(pwdata_i[6]))
		else $error("pin connect does not follow the written bit");

	range_follow_a: assert property (ctrl_wr |=> ladder_low_range_o == $past(pwdata_i[5]))
		else $error("range does not follow the written bit");

	unused_zero_a: assert property (setup && hit_ctrl |=> prdata_o[4] == 1'b0
		&& prdata_o[7:0] == ctrl_q)
		else $error("unimplemented bit reads back nonzero");

	tap_line_a: assert property (ctrl_wr && pwdata_i[7] |=>
		(ladder_low_range_o ? ladder_low_taps_o : ladder_high_taps_o)
		== 16'h0001 << $past(pwdata_i[3:0])
		&& (ladder_low_range_o ? ladder_high_taps_o : ladder_low_taps_o) == 16'h0000)
		else $error("selected tap line wrong");

	low_ratio_a: assert property (ctrl_wr && pwdata_i[5] |=> ladder_ratio_den_o == 6'h18
		&& ladder_ratio_num_o == {2'h0, $past(pwdata_i[3:0])})
		else $error("low range ratio wrong");

	high_ratio_a: assert property (ctrl_wr && !pwdata_i[5] |=> ladder_ratio_den_o == 6'h20
		&& ladder_ratio_num_o == 6'h08 + {2'h0, $past(pwdata_i[3:0])})
		else $error("high range ratio wrong");

	write_hold_a: assert property (!ctrl_wr |=> $stable(ctrl_q))
		else $error("control register changed without a write");

	settle_start_a: assert property (ctrl_change |=> ladder_settling_o [*2])
		else $error("settling window not opened by a level change");

	unmapped_err_a: assert property (setup && unmapped |=> pslverr_o == access)
		else $error("unmapped access not flagged");

	// steady-state checks: they hold on every cycle, so they also catch a
	// decoder that drifts away from the register between writes
	taps_dark_a: assert property (!ladder_power_on_o |->
		(ladder_low_taps_o | ladder_high_taps_o) == 16'h0000)
		else $error("tap line live while powered down");

	tap_onehot_a: assert property (ladder_power_on_o |->
		$onehot(ladder_low_taps_o | ladder_high_taps_o))
		else $error("powered ladder does not have exactly one tap line");

	tap_match_a: assert property (ladder_power_on_o |->
		(ladder_low_taps_o | ladder_high_taps_o) == 16'h0001 << ladder_tap_select_o)
		else $error("live tap line differs from the tap field");

	range_lines_a: assert property (
		(ladder_low_range_o ? ladder_high_taps_o : ladder_low_taps_o) == 16'h0000)
		else $error("tap line live in the unselected range");

	unused_store_a: assert property (ctrl_q[vref_pkg::UNUSED_BIT] == 1'b0)
		else $error("unimplemented bit stored");

	low_level_a: assert property (ladder_low_range_o |->
		ladder_ratio_num_o == {2'h0, ladder_tap_select_o}
		&& ladder_ratio_den_o == vref_pkg::LOW_DEN)
		else $error("low range level ratio wrong");

	high_level_a: assert property (!ladder_low_range_o |->
		ladder_ratio_num_o == vref_pkg::HIGH_BASE + {2'h0, ladder_tap_select_o}
		&& ladder_ratio_den_o == vref_pkg::HIGH_DEN)
		else $error("high range level ratio wrong");

	strobe_gate_a: assert property (wr_ctrl && !pstrb_i[0] |=> $stable(ctrl_q))
		else $error("write without the low byte strobe changed the register");

	write_land_a: assert property (wr_ctrl && pstrb_i[0] |=>
		ctrl_q == ($past(pwdata_i[7:0]) & vref_pkg::CTRL_WMASK))
		else $error("written value not stored");

	read_word_a: assert property (access && !pwrite_i && hit_ctrl |->
		prdata_o == {24'h000000, ctrl_q})
		else $error("control read data does not match the register");

	stat_word_a: assert property (access && !pwrite_i && hit_stat |->
		prdata_o[vref_pkg::STAT_NUM_LSB +: vref_pkg::RATIO_W] == ladder_ratio_num_o
		&& prdata_o[vref_pkg::STAT_DEN_LSB +: vref_pkg::RATIO_W] == ladder_ratio_den_o)
		else $error("status read data does not match the ladder level");

	mapped_ok_a: assert property (access && !unmapped |-> !pslverr_o)
		else $error("error raised on a mapped register");

	settle_end_a: assert property (settle_q == SETTLE_CW'(1) && !ctrl_change |=>
		!ladder_settling_o)
		else $error("settling window did not close");

	low_write_c: cover property (ctrl_wr && pwdata_i[7] && pwdata_i[5] && pwdata_i[6]);
	high_write_c: cover property (ctrl_wr && pwdata_i[7] && !pwdata_i[5] && pwdata_i[3:0] == 4'hF);
	stat_settle_c: cover property (setup && hit_stat && !pwrite_i && ladder_settling_o);
	unmapped_c: cover property (access && unmapped);
	refused_write_c: cover property (wr_ctrl && !pstrb_i[0]);

endmodule

// [tb/tb_vref_ladder_control.sv]
// self-checking bench for the reference ladder control block
`timescale 1ns/100ps
module tb;
	// ****************************************
	// clock, reset and bus signals
	// ****************************************
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [vref_pkg::ADDR_W-1:0] paddr = '0;
	logic [vref_pkg::DATA_W-1:0] pwdata = '0;
	logic [3:0] pstrb = 4'h0;
	wire logic [vref_pkg::DATA_W-1:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic power_on;
	wire logic pin_connect;
	wire logic low_range;
	wire logic [3:0] tap_sel;
	wire logic [15:0] low_taps;
	wire logic [15:0] high_taps;
	wire logic [5:0] ratio_num;
	wire logic [5:0] ratio_den;
	wire logic settling;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;
	logic [7:0] v;
	logic [7:0] shadow;

	// settle shortened to 5 cycles so the tracker is exercised quickly
	vref_ladder_control #(.SETTLE_NS(100)) uut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ladder_power_on_o(power_on), .ladder_pin_connect_o(pin_connect),
		.ladder_low_range_o(low_range), .ladder_tap_select_o(tap_sel),
		.ladder_low_taps_o(low_taps), .ladder_high_taps_o(high_taps),
		.ladder_ratio_num_o(ratio_num), .ladder_ratio_den_o(ratio_den),
		.ladder_settling_o(settling)
	);

	// 50 MHz clock
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// hang guard, far above the roughly five hundred cycles the tests need
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			$display("[ERR] %0t run timed out", $time);
			report_and_stop();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		@(posedge sys_clk_i);
		while (pready !== 1'b1) @(posedge sys_clk_i);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// an idle edge keeps the next setup from overwriting this release
		@(posedge sys_clk_i);
	endtask

	// one-hot tap line expected in one range, dark while powered down
	function automatic logic [15:0] exp_taps(input logic [7:0] r, input logic want_low);
		exp_taps = (r[7] && (r[5] == want_low)) ? 16'h0001 << r[3:0] : 16'h0000;
	endfunction

	// level numerator: tap over 24 low, quarter (8/32) plus tap over 32 high
	function automatic logic [5:0] exp_num(input logic [7:0] r);
		exp_num = r[5] ? {2'h0, r[3:0]} : 6'h08 + {2'h0, r[3:0]};
	endfunction

	function automatic logic [5:0] exp_den(input logic [7:0] r);
		exp_den = r[5] ? 6'h18 : 6'h20;
	endfunction

	// status word: settling, any tap live, numerator, denominator
	function automatic logic [31:0] exp_stat(input logic [7:0] r, input logic busy);
		exp_stat = {10'h000, exp_den(r), 2'h0, exp_num(r), 6'h00, r[7], busy};
	endfunction

	// expected ladder outputs worked out from a register value
	task automatic check_outs(input logic [7:0] r);
		@(negedge sys_clk_i);
		chk(power_on, r[7], "power");
		chk(pin_connect, r[6], "pin");
		chk(low_range, r[5], "range");
		chk(tap_sel, r[3:0], "tap");
		chk(low_taps, exp_taps(r, 1'b1), "low taps");
		chk(high_taps, exp_taps(r, 1'b0), "high taps");
		chk(ratio_num, exp_num(r), "num");
		chk(ratio_den, exp_den(r), "den");
		@(posedge sys_clk_i);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(94));
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		check_outs(8'h00);
		apb(1'b0, vref_pkg::CTRL_ADDR, 32'h0, 4'hF);
		chk(rd, 32'h0, "reset readback");
		$display("test reset done");
		// every tap in both ranges powered, then again with random power; bit 4 at random
		for (int i = 0; i < 64; i++) begin
			v = 8'($urandom);
			v[5] = i[4];
			v[3:0] = i[3:0];
			if (!i[5]) v[7] = 1'b1;
			apb(1'b1, vref_pkg::CTRL_ADDR, {24'($urandom), v}, 4'hF);
			chk(err, 1'b0, "write error");
			shadow = v & 8'hEF;
			check_outs(shadow);
			apb(1'b0, vref_pkg::CTRL_ADDR, 32'h0, 4'hF);
			chk(rd, {24'h0, shadow}, "readback");
		end
		$display("test taps done");
		// refused writes leave the register alone
		apb(1'b1, vref_pkg::CTRL_ADDR, 32'h0000_00FF, 4'h0);
		check_outs(shadow);
		apb(1'b1, 12'h000, 32'h0000_00FF, 4'hF);
		chk(err, 1'b1, "unmapped write error");
		apb(1'b0, 12'h000, 32'h0, 4'hF);
		chk(err, 1'b1, "unmapped read error");
		chk(rd, 32'h0, "unmapped read data");
		apb(1'b1, vref_pkg::STAT_ADDR, 32'h0000_00FF, 4'hF);
		chk(err, 1'b0, "status write error");
		check_outs(shadow);
		$display("test refusals done");
		// a changed value raises the settling flag, which then drops
		v = shadow ^ 8'h8F;
		apb(1'b1, vref_pkg::CTRL_ADDR, {24'h0, v}, 4'hF);
		@(negedge sys_clk_i);
		chk(settling, 1'b1, "settling high");
		@(posedge sys_clk_i);
		// window is five cycles, so the status setup still finds it open
		apb(1'b0, vref_pkg::STAT_ADDR, 32'h0, 4'hF);
		chk(rd, exp_stat(v, 1'b1), "status while settling");
		repeat (10) @(posedge sys_clk_i);
		#1;
		chk(settling, 1'b0, "settling low");
		@(posedge sys_clk_i);
		apb(1'b0, vref_pkg::STAT_ADDR, 32'h0, 4'hF);
		chk(rd, exp_stat(v, 1'b0), "status after settling");
		chk(err, 1'b0, "status read error");
		$display("test settling done");
		// reset in mid-run clears everything at once
		@(posedge sys_clk_i);
		apb(1'b1, vref_pkg::CTRL_ADDR, 32'h0000_00FF, 4'hF);
		nrst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({power_on, pin_connect, low_range, tap_sel}, 32'h0, "async clear");
		@(posedge sys_clk_i);
		nrst_i <= 1'b1;
		check_outs(8'h00);
		$display("test midrun reset done");
		report_and_stop();
	end
endmodule
